/* File: include/tmr_wave_pkg.sv */
// Purpose: shared constants and types for the timer waveform block
// Assumes: 8-bit counter, 8-bit register bus, 3-bit register index
// Notes:   offsets are register indices on the plain register port

package tmr_wave_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int unsigned ADDR_W      = 3;
  localparam logic [2:0]  OFS_CTRL    = 3'h0;  // mode, action, force
  localparam logic [2:0]  OFS_COUNT   = 3'h1;  // count_value
  localparam logic [2:0]  OFS_COMPARE = 3'h2;  // compare_value
  localparam logic [2:0]  OFS_FLAGS   = 3'h3;  // write one to clear
  localparam logic [2:0]  OFS_PIN     = 3'h4;  // port, direction, levels

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_ACT_LSB   = 2;
  localparam int unsigned CTRL_FORCE_BIT = 7;
  localparam int unsigned FLAG_OVF_BIT   = 0;
  localparam int unsigned FLAG_CMP_BIT   = 1;
  localparam int unsigned PIN_PORT_BIT   = 0;
  localparam int unsigned PIN_DIR_BIT    = 1;
  localparam int unsigned PIN_LEVEL_BIT  = 2;
  localparam int unsigned PIN_LATCH_BIT  = 3;

  // ****************************************
  // counter extremes and reset values
  // ****************************************
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_RST    = 8'h00;
  localparam logic [7:0] COMPARE_RST  = 8'h00;
  localparam logic [7:0] RDATA_RST    = 8'h00;

  // ****************************************
  // modes and actions
  // ****************************************
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_PHASE  = 2'h1,  // not served: counts as normal, no output
    MODE_CLEAR  = 2'h2,
    MODE_FAST   = 2'h3
  } wave_mode_t;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } out_action_t;

  // register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } bus_req_t;

endpackage

/* File: hw/tmr_wave.sv */
// Purpose: compare output and waveform modes of an 8-bit timer
// Assumes: tick_i is a one-cycle count enable from a prescaler
// Notes:   all state freezes while ce_i is low
//
// Notes on behaviour
// - nonzero action select drives pin from latch
// - pin direction stays with the direction bit
// - reset clears the compare output latch
// - action zero leaves latch unchanged at match
// - new action applies from next match
// - force strobe applies action at once, non-PWM
// - override ignores the wave mode
// - normal mode increments, wraps max to zero
// - normal overflow flag set when count wraps
// - count writes accepted any time
// - clear mode zeroes counter on match
// - clear mode compare unbuffered, may wrap first
// - clear mode sets compare flag at top
// - clear mode action one toggles each match
// - clear mode overflow only on max to zero
// - fast PWM counts to max then clears
// - fast PWM action two/three set polarity
// - fast PWM overflow flag set at max
// - fast PWM extremes: spike or constant level
// - PWM compare writes buffered, loaded at bottom
// - match sets compare flag next tick
// - count write blocks match at next tick
// - force sets no flag, leaves counter
//
// Our own choices: the placing of the registers and strobed register access.

`timescale 1ns/1ps
`default_nettype none

module tmr_wave (
  // clock, reset, enable
  input  wire logic                  clk_sys_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  ce_i,
  // prescaled count enable
  input  wire logic                  tick_i,
  // register port
  input  wire tmr_wave_pkg::bus_req_t bus_i,
  output logic [7:0]                 rdata_o,
  // flag clears from interrupt execution
  input  wire logic                  ovf_ack_i,
  input  wire logic                  cmp_ack_i,
  // event flags
  output logic                       overflow_flag_o,
  output logic                       compare_flag_o,
  // general I/O pin
  input  wire logic                  pin_i,
  output logic                       pin_o,
  output logic                       pin_oe_o
);

  // ****************************************
  // state
  // ****************************************
  tmr_wave_pkg::wave_mode_t  wave_mode_select;     // counting sequence
  tmr_wave_pkg::out_action_t output_action_select; // latch action
  logic [7:0] count_value;          // counter
  logic [7:0] compare_value;        // active compare value
  logic [7:0] compare_buf;          // software-side buffer
  logic       compare_output_latch; // waveform state
  logic       overflow_flag;        // sticky overflow
  logic       compare_flag;         // sticky compare
  logic       port_bit;             // general port output
  logic       compare_pin_direction_bit; // pin drives when high
  logic       block_q;              // match blocked at next tick
  logic       pin_meta;             // first sync stage
  logic       pin_sync;             // second sync stage

  // ****************************************
  // decode
  // ****************************************
  logic wr_ctrl, wr_count, wr_cmp, wr_flags, wr_pin;
  logic is_pwm, tick, match, match_eff, bottom_evt;
  logic force_wr;
  tmr_wave_pkg::out_action_t force_act;

  // address compare, used by every strobe
  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  // new latch value for an action; pwm mode knows no toggle
  function automatic logic apply_act(input logic cur,
                                     input tmr_wave_pkg::out_action_t a,
                                     input logic pwm);
    case (a)
      tmr_wave_pkg::ACT_TOGGLE: apply_act = pwm ? cur : ~cur;
      tmr_wave_pkg::ACT_CLEAR:  apply_act = 1'b0;
      tmr_wave_pkg::ACT_SET:    apply_act = 1'b1;
      default:                  apply_act = cur;
    endcase
  endfunction

  assign wr_ctrl  = bus_i.we && hit(bus_i.addr, tmr_wave_pkg::OFS_CTRL);
  assign wr_count = bus_i.we && hit(bus_i.addr, tmr_wave_pkg::OFS_COUNT);
  assign wr_cmp   = bus_i.we && hit(bus_i.addr, tmr_wave_pkg::OFS_COMPARE);
  assign wr_flags = bus_i.we && hit(bus_i.addr, tmr_wave_pkg::OFS_FLAGS);
  assign wr_pin   = bus_i.we && hit(bus_i.addr, tmr_wave_pkg::OFS_PIN);

  // phase correct is left pwm-buffered so force stays off there
  assign is_pwm = wave_mode_select[0];

  // force uses the action being written in the same word
  assign force_act = tmr_wave_pkg::out_action_t'(
                       bus_i.wdata[tmr_wave_pkg::CTRL_ACT_LSB +: 2]);
  assign force_wr  = wr_ctrl && bus_i.wdata[tmr_wave_pkg::CTRL_FORCE_BIT]
                     && !bus_i.wdata[tmr_wave_pkg::CTRL_MODE_LSB];

  assign tick       = tick_i;
  assign match      = (count_value == compare_value);
  assign match_eff  = tick && match && !block_q;
  assign bottom_evt = tick && !wr_count && (count_value == tmr_wave_pkg::COUNT_MAX);

  // ****************************************
  // control register
  // ****************************************
  // action change takes no effect until the next match, force or fast PWM bottom
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wave_mode_select     <= tmr_wave_pkg::MODE_NORMAL;
      output_action_select <= tmr_wave_pkg::ACT_NONE;
    end else if (ce_i && wr_ctrl) begin
      wave_mode_select     <= tmr_wave_pkg::wave_mode_t'(
                                bus_i.wdata[tmr_wave_pkg::CTRL_MODE_LSB +: 2]);
      output_action_select <= force_act;
    end
  end

  // ****************************************
  // counter
  // ****************************************
  // software write beats clear and count
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      count_value <= tmr_wave_pkg::COUNT_RST;
    end else if (ce_i) begin
      if (wr_count) begin
        count_value <= bus_i.wdata;
      end else if (tick) begin
        if (wave_mode_select == tmr_wave_pkg::MODE_CLEAR && match_eff) begin
          count_value <= tmr_wave_pkg::COUNT_BOTTOM;
        end else if (wave_mode_select == tmr_wave_pkg::MODE_FAST
                     && count_value == tmr_wave_pkg::COUNT_MAX) begin
          count_value <= tmr_wave_pkg::COUNT_BOTTOM;
        end else begin
          count_value <= count_value + 8'h01;
        end
      end
    end
  end

  // ****************************************
  // match blocking after a count write
  // ****************************************
  // holds until a tick passes, even with the timer stopped
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      block_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_count) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // compare value and buffer
  // ****************************************
  // unbuffered in non-pwm modes, so a value below count wraps first
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      compare_value <= tmr_wave_pkg::COMPARE_RST;
      compare_buf   <= tmr_wave_pkg::COMPARE_RST;
    end else if (ce_i) begin
      if (wr_cmp) begin
        compare_buf <= bus_i.wdata;
      end
      if (wr_cmp && !is_pwm) begin
        compare_value <= bus_i.wdata;
      end else if (is_pwm && bottom_evt) begin
        compare_value <= compare_buf;
      end
    end
  end

  // ****************************************
  // compare output latch
  // ****************************************
  // bottom beats match so compare at max gives a constant level
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      compare_output_latch <= 1'b0;
    end else if (ce_i) begin
      if (force_wr) begin
        compare_output_latch <=
          apply_act(compare_output_latch, force_act, 1'b0);
      end else if (wave_mode_select == tmr_wave_pkg::MODE_FAST && bottom_evt
                   && output_action_select[1]) begin
        compare_output_latch <= ~output_action_select[0];
      end else if (match_eff && wave_mode_select != tmr_wave_pkg::MODE_PHASE) begin
        compare_output_latch <= apply_act(compare_output_latch,
                                  output_action_select, is_pwm);
      end
    end
  end

  // ****************************************
  // event flags
  // ****************************************
  // set wins over a clear arriving in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      overflow_flag <= 1'b0;
    end else if (ce_i) begin
      if (bottom_evt) begin
        overflow_flag <= 1'b1;
      end else if (ovf_ack_i ||
                   (wr_flags && bus_i.wdata[tmr_wave_pkg::FLAG_OVF_BIT])) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  // force never reaches this flag
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      compare_flag <= 1'b0;
    end else if (ce_i) begin
      if (match_eff) begin
        compare_flag <= 1'b1;
      end else if (cmp_ack_i ||
                   (wr_flags && bus_i.wdata[tmr_wave_pkg::FLAG_CMP_BIT])) begin
        compare_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // pin port and synchroniser
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      port_bit                  <= 1'b0;
      compare_pin_direction_bit <= 1'b0;
    end else if (ce_i && wr_pin) begin
      port_bit                  <= bus_i.wdata[tmr_wave_pkg::PIN_PORT_BIT];
      compare_pin_direction_bit <= bus_i.wdata[tmr_wave_pkg::PIN_DIR_BIT];
    end
  end

  // pin level is only read back, two stages suffice
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else if (ce_i) begin
      pin_meta <= pin_i;
      pin_sync <= pin_meta;
    end
  end

  // override depends on action only, never on mode
  assign pin_o    = (output_action_select != tmr_wave_pkg::ACT_NONE)
                    ? compare_output_latch : port_bit;
  assign pin_oe_o = compare_pin_direction_bit;

  assign overflow_flag_o = overflow_flag;
  assign compare_flag_o  = compare_flag;

  // ****************************************
  // read data
  // ****************************************
  // force bit reads zero; unmapped index reads zero
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_o <= tmr_wave_pkg::RDATA_RST;
    end else if (ce_i) begin
      rdata_o <= tmr_wave_pkg::RDATA_RST;
      if (bus_i.re) begin
        if (hit(bus_i.addr, tmr_wave_pkg::OFS_CTRL)) begin
          rdata_o <= {4'h0, output_action_select, wave_mode_select};
        end else if (hit(bus_i.addr, tmr_wave_pkg::OFS_COUNT)) begin
          rdata_o <= count_value;
        end else if (hit(bus_i.addr, tmr_wave_pkg::OFS_COMPARE)) begin
          rdata_o <= compare_buf;
        end else if (hit(bus_i.addr, tmr_wave_pkg::OFS_FLAGS)) begin
          rdata_o <= {6'h00, compare_flag, overflow_flag};
        end else if (hit(bus_i.addr, tmr_wave_pkg::OFS_PIN)) begin
          rdata_o <= {4'h0, compare_output_latch, pin_sync,
                      compare_pin_direction_bit, port_bit};
        end
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  property p_override;
    pin_o == ((output_action_select != tmr_wave_pkg::ACT_NONE)
              ? compare_output_latch : port_bit);
  endproperty
  a_override: assert property (p_override) else $error("pin source wrong");

  property p_dir;
    ce_i && wr_pin |=> pin_oe_o == $past(bus_i.wdata[tmr_wave_pkg::PIN_DIR_BIT]);
  endproperty
  a_dir: assert property (p_dir) else $error("pin enable wrong");

  property p_reset;
    $past(!reset_n_i) |-> !compare_output_latch;
  endproperty
  a_reset: assert property (p_reset) else $error("latch not cleared");

  property p_none_hold;
    ce_i && output_action_select == tmr_wave_pkg::ACT_NONE && !force_wr
      && !(wave_mode_select == tmr_wave_pkg::MODE_FAST && bottom_evt)
      |=> $stable(compare_output_latch);
  endproperty
  a_none_hold: assert property (p_none_hold) else $error("latch moved");

  property p_normal_inc;
    ce_i && tick && !wr_count && wave_mode_select == tmr_wave_pkg::MODE_NORMAL
      |=> count_value == $past(count_value) + 8'h01;
  endproperty
  a_normal_inc: assert property (p_normal_inc) else $error("no increment");

  property p_ovf;
    ce_i && bottom_evt |=> overflow_flag && count_value == tmr_wave_pkg::COUNT_BOTTOM;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");

  property p_match_clear;
    ce_i && !wr_count && match_eff && wave_mode_select == tmr_wave_pkg::MODE_CLEAR
      |=> count_value == tmr_wave_pkg::COUNT_BOTTOM && compare_flag;
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("no clear on match");

  property p_block;
    ce_i && wr_count ##1 (ce_i && tick && !wr_count && !compare_flag && !cmp_ack_i)
      |=> !compare_flag;
  endproperty
  a_block: assert property (p_block) else $error("match not blocked");

  property p_force;
    ce_i && force_wr && force_act == tmr_wave_pkg::ACT_SET && !compare_flag
      && !match_eff |=> compare_output_latch && !compare_flag;
  endproperty
  a_force: assert property (p_force) else $error("force wrong");

  property p_fast_bottom;
    ce_i && bottom_evt && !force_wr && wave_mode_select == tmr_wave_pkg::MODE_FAST
      && output_action_select == tmr_wave_pkg::ACT_CLEAR |=> compare_output_latch;
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("bottom set lost");

  c_match_toggle: cover property (ce_i && match_eff
    && wave_mode_select == tmr_wave_pkg::MODE_CLEAR
    && output_action_select == tmr_wave_pkg::ACT_TOGGLE);
  c_fast_spike: cover property (ce_i && bottom_evt
    && wave_mode_select == tmr_wave_pkg::MODE_FAST
    && compare_value == tmr_wave_pkg::COUNT_BOTTOM);
  c_force: cover property (ce_i && force_wr);

endmodule

`default_nettype wire

/* File: hw/README_unused_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: test/gpio_pin_model.sv */
// Purpose: model of the general I/O pad beyond the timer pin
// Assumes: a weak pull-up holds the pad high when nobody drives it
// Notes:   the resolved level goes back to the timer's pin input
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_model (
  // from the timer pin driver
  input  wire logic drive_i,
  input  wire logic enable_i,
  // resolved pad level
  output logic      level_o
);
  // ****************************************
  // pad resolution
  // ****************************************
  // released pad goes to the pull-up, never to the last driven value
  always_comb begin
    if (enable_i === 1'b1) begin
      level_o = drive_i;  // timer drives the pad
    end else begin
      level_o = 1'b1;     // pull-up wins when released
    end
  end
endmodule
`default_nettype wire

/* File: test/test_tmr_wave.sv */
// Purpose: self-checking bench for the timer waveform block
// Assumes: the bench plays software and the prescaler tick
// Notes:   table rows for counting cases, hand tests for the rest
`timescale 1ns/1ps
`default_nettype none

module test_tmr_wave;
  // ****************************************
  // signals
  // ****************************************
  logic                   clk_sys_i;  // 25 MHz clock
  logic                   reset_n_i;  // synchronous reset
  logic                   ce_i;       // run enable
  logic                   tick_i;     // timer count enable
  tmr_wave_pkg::bus_req_t bus_i;      // register request
  logic [7:0]             rdata_o;    // read data
  logic                   ovf_ack_i;  // overflow interrupt taken
  logic                   cmp_ack_i;  // compare interrupt taken
  logic                   overflow_flag_o;
  logic                   compare_flag_o;
  logic                   pin_i;      // pad level back in
  logic                   pin_o;
  logic                   pin_oe_o;
  logic                   lv;         // last seen pin level
  int                     fail_count;
  int                     comparisons;
  localparam logic [2:0] A_CTRL = tmr_wave_pkg::OFS_CTRL;
  localparam logic [2:0] A_CNT  = tmr_wave_pkg::OFS_COUNT;
  localparam logic [2:0] A_CMP  = tmr_wave_pkg::OFS_COMPARE;
  localparam logic [2:0] A_FLG  = tmr_wave_pkg::OFS_FLAGS;
  localparam logic [2:0] A_PIN  = tmr_wave_pkg::OFS_PIN;

  // one counting case: setup, tick count, expected state
  typedef struct {
    logic [1:0] mode; logic [1:0] act; logic [7:0] cmp; logic [7:0] start; int nt;
    logic [7:0] cnt;  logic ovf;       logic cf;        logic lat;
  } row_t;
  // first tick after the count write never matches
  row_t rows [12] = '{
    '{2'h0, 2'h0, 8'h10, 8'hfe, 2,   8'h00, 1'b1, 1'b0, 1'b0},
    '{2'h0, 2'h0, 8'h05, 8'h05, 1,   8'h06, 1'b0, 1'b0, 1'b0},
    '{2'h0, 2'h1, 8'h05, 8'h04, 3,   8'h07, 1'b0, 1'b1, 1'b1},
    '{2'h2, 2'h1, 8'h03, 8'h00, 4,   8'h00, 1'b0, 1'b1, 1'b1},
    '{2'h2, 2'h0, 8'h03, 8'h00, 4,   8'h00, 1'b0, 1'b1, 1'b0},
    '{2'h2, 2'h0, 8'h02, 8'h05, 252, 8'h01, 1'b1, 1'b0, 1'b0},
    '{2'h3, 2'h2, 8'h80, 8'hfe, 2,   8'h00, 1'b1, 1'b0, 1'b1},
    '{2'h3, 2'h3, 8'h80, 8'h7f, 2,   8'h81, 1'b0, 1'b1, 1'b1},
    '{2'h3, 2'h1, 8'h80, 8'h7f, 2,   8'h81, 1'b0, 1'b1, 1'b0},
    '{2'h3, 2'h2, 8'h01, 8'hfe, 4,   8'h02, 1'b1, 1'b1, 1'b0},
    '{2'h3, 2'h2, 8'hff, 8'hfe, 2,   8'h00, 1'b1, 1'b1, 1'b1},
    '{2'h3, 2'h2, 8'h00, 8'hfe, 3,   8'h01, 1'b1, 1'b1, 1'b0}
  };

  // ****************************************
  // design and pad
  // ****************************************
  tmr_wave dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .tick_i(tick_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .ovf_ack_i(ovf_ack_i), .cmp_ack_i(cmp_ack_i),
    .overflow_flag_o(overflow_flag_o), .compare_flag_o(compare_flag_o),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o)
  );
  gpio_pin_model pad (.drive_i(pin_o), .enable_i(pin_oe_o), .level_o(pin_i));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask
  // one write, optionally with a tick in the same cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic tk);
    @(posedge clk_sys_i);
    bus_i  <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    tick_i <= tk;
    @(posedge clk_sys_i);
    bus_i  <= '0;
    tick_i <= 1'b0;
  endtask
  // read, mask, compare; data stand only in the cycle after the strobe
  task automatic rreg(input string n, input logic [2:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge clk_sys_i);
    bus_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1 chk8(n, e, rdata_o & m);
  endtask
  task automatic ticks(input int n);
    @(posedge clk_sys_i);
    tick_i <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    tick_i <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // clock and hang guard
  // ****************************************
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fail_count++;
    print_verdict();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset_n_i = 1'b0;
    ce_i = 1'b1;
    tick_i = 1'b0;
    bus_i = '0;
    ovf_ack_i = 1'b0;
    cmp_ack_i = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (20) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    #1 chk1("pin_oe_o reset", 1'b0, pin_oe_o);
    for (int i = 0; i < 6; i++) begin
      // pad pulled up shows in the synced level bit; index 5 unmapped
      rreg("reset value", i[2:0], 8'hff, (i == 4) ? 8'h04 : 8'h00);
    end
    wr(3'h5, 8'hff, 1'b0);
    rreg("unmapped", 3'h5, 8'hff, 8'h00);
    // table of counting cases; force-clear puts the latch at 0 first
    foreach (rows[i]) begin
      wr(A_CTRL, 8'h88, 1'b0);
      wr(A_CMP, rows[i].cmp, 1'b0);
      wr(A_CNT, rows[i].start, 1'b0);
      wr(A_FLG, 8'h03, 1'b0);
      wr(A_CTRL, {4'h0, rows[i].act, rows[i].mode}, 1'b0);
      ticks(rows[i].nt);
      rreg("count", A_CNT, 8'hff, rows[i].cnt);
      rreg("flags", A_FLG, 8'hff, {6'h00, rows[i].cf, rows[i].ovf});
      rreg("latch", A_PIN, 8'h08, {4'h0, rows[i].lat, 3'h0});
    end
    // flags stay until the interrupt acknowledges them
    chk1("overflow_flag_o", 1'b1, overflow_flag_o);
    chk1("compare_flag_o", 1'b1, compare_flag_o);
    @(posedge clk_sys_i);
    ovf_ack_i <= 1'b1;
    @(posedge clk_sys_i);
    ovf_ack_i <= 1'b0;
    rreg("ovf ack", A_FLG, 8'hff, 8'h02);
    @(posedge clk_sys_i);
    cmp_ack_i <= 1'b1;
    @(posedge clk_sys_i);
    cmp_ack_i <= 1'b0;
    rreg("cmp ack", A_FLG, 8'hff, 8'h00);
    // forced compare: latch only, no flag, no count change
    wr(A_CTRL, 8'h88, 1'b0);
    wr(A_CMP, 8'h35, 1'b0);
    wr(A_CNT, 8'h33, 1'b0);
    wr(A_FLG, 8'h03, 1'b0);
    wr(A_CTRL, 8'h8c, 1'b0);
    wr(A_CTRL, 8'h8b, 1'b0);  // ignored in fast pwm
    wr(A_CTRL, 8'h08, 1'b0);  // clear action waits for a match
    rreg("forced latch", A_PIN, 8'h08, 8'h08);
    rreg("count after force", A_CNT, 8'hff, 8'h33);
    rreg("flags after force", A_FLG, 8'hff, 8'h00);
    rreg("ctrl readback", A_CTRL, 8'hff, 8'h08);
    ticks(3);
    rreg("latch at match", A_PIN, 8'h08, 8'h00);
    // pin override in every mode
    wr(A_CTRL, 8'h8c, 1'b0);
    wr(A_PIN, 8'h02, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, {6'h03, m[1:0]}, 1'b0);
      #1 chk1("pin_o latch", 1'b1, pin_o);
      chk1("pin_oe_o", 1'b1, pin_oe_o);
    end
    wr(A_CTRL, 8'h00, 1'b0);
    #1 chk1("pin_o port", 1'b0, pin_o);
    wr(A_PIN, 8'h01, 1'b0);
    #1 chk1("pin_oe_o off", 1'b0, pin_oe_o);
    // clear-on-match with top zero toggles every tick
    wr(A_CMP, 8'h00, 1'b0);
    wr(A_CNT, 8'hff, 1'b0);
    wr(A_PIN, 8'h02, 1'b0);
    wr(A_CTRL, 8'h06, 1'b0);
    @(posedge clk_sys_i);
    tick_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 lv = pin_o;
    repeat (3) begin
      @(posedge clk_sys_i);
      #1 chk1("pin_o toggle", ~lv, pin_o);
      lv = pin_o;
    end
    @(posedge clk_sys_i);
    tick_i <= 1'b0;
    // fast pwm holds a new compare in the buffer
    wr(A_CTRL, 8'h88, 1'b0);
    wr(A_CMP, 8'h10, 1'b0);
    wr(A_CNT, 8'h0e, 1'b0);
    wr(A_FLG, 8'h03, 1'b0);
    wr(A_CTRL, 8'h03, 1'b0);
    wr(A_CMP, 8'h20, 1'b0);
    ticks(3);
    rreg("buffered match", A_FLG, 8'hff, 8'h02);
    rreg("compare buffer", A_CMP, 8'hff, 8'h20);
    // count write beside a tick, then a frozen enable
    wr(A_CTRL, 8'h00, 1'b0);
    wr(A_CNT, 8'h40, 1'b1);
    rreg("count write wins", A_CNT, 8'hff, 8'h40);
    @(posedge clk_sys_i);
    ce_i   <= 1'b0;
    tick_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    ce_i   <= 1'b1;
    tick_i <= 1'b0;
    rreg("count frozen", A_CNT, 8'hff, 8'h40);
    // count write, then a tick at once: that tick must not match
    wr(A_CMP, 8'h50, 1'b0);
    wr(A_FLG, 8'h03, 1'b0);
    @(posedge clk_sys_i);
    bus_i  <= '{addr: A_CNT, wdata: 8'h50, we: 1'b1, re: 1'b0};
    @(posedge clk_sys_i);
    bus_i  <= '0;
    tick_i <= 1'b1;
    @(posedge clk_sys_i);
    tick_i <= 1'b0;
    rreg("blocked flag", A_FLG, 8'hff, 8'h00);
    rreg("count past block", A_CNT, 8'hff, 8'h51);
    // reset in mid-run clears a set latch
    wr(A_CTRL, 8'h8c, 1'b0);
    @(posedge clk_sys_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    rreg("latch after reset", A_PIN, 8'h08, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
